// file: common/sbdac_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types of the stereo bitstream converter
// Assumes: one clock, mclk, serves as the conversion clock
// Notes:   status and mask vectors hold underrun in bit 0, ready in bit 1
//////////////////////////////////////////////////////////////////////////////
package sbdac_pkg;
   localparam int SB_MCLK_HZ = 20_000_000;
   // clocks per input sample, the conversion clock being 256 times fs
   localparam int SB_CLK_PER_SMP = 256;
   // fixed oversampling ratio, not a port and not a parameter on purpose
   localparam int SB_OSR = 128;
   localparam int SB_CLK_PER_OS = SB_CLK_PER_SMP / SB_OSR;
   localparam int SB_SMP_W = 16;
   localparam int SB_FIFO_DEPTH = 8;
   localparam int SB_FIR_W = 20;
   localparam int SB_CIC_ORDER = 4;
   localparam int SB_CIC_W = 48;
   // interpolator gain is osr to the power order-1, that is 2**21
   localparam int SB_CIC_SHIFT = 21;
   localparam int SB_SDM_ORDER = 3;
   localparam int SB_SDM_W = 24;
   localparam int SB_SDM_FS_LOG2 = 17;
   localparam logic [7:0] SB_PHASE_LAST = 8'hff;
   localparam int SB_FLAG_UNDERRUN = 0;
   localparam int SB_FLAG_SAMPLE_READY_FLAG = 1;
   localparam logic [1:0] SB_FLAGS_RESET = 2'h0;

   typedef struct packed {
      logic signed [SB_SMP_W-1:0] right_sample_field;
      logic signed [SB_SMP_W-1:0] left_sample_field;
   } sbdac_pair_type;

   typedef enum logic [1:0] {
      SB_IDLE = 2'b00,
      SB_PRIME = 2'b01,
      SB_RUN = 2'b10
   } sbdac_state_type;
endpackage

// file: dv/sbdac_lpf_model.sv
// Purpose: stand-in for the low-pass filter on one channel's bitstream pins
// Assumes: one sample of the pins per mclk edge
// Notes:   box-car count of ones; the bench clears it to open a window
`timescale 1ns/1ns
module sbdac_lpf_model (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // window control
   input wire logic clear,
   // complementary pins
   input wire logic bit_true,
   input wire logic bit_inv,
   // filtered view
   output logic [15:0] ones_q,
   output logic comp_err_q
);
   // only the mean matters to an analog filter, so a plain count is enough
   always_ff @(posedge mclk) begin
      if (srst || clear) begin
         ones_q <= 16'h0000;
      end else begin
         ones_q <= ones_q + {15'h0000, bit_true};
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         comp_err_q <= 1'b0;
      end else if (bit_true === bit_inv) begin
         comp_err_q <= 1'b1;
      end
   end
endmodule

// file: dv/test_stereo_sigma_delta_bitstream_dac.sv
// Purpose: self-checking bench of the stereo bitstream converter
// Assumes: feeder writes a pair on every cycle while feeding
// Notes:   averages are judged by side of mid-scale, not exact level
`timescale 1ns/1ns
module test_stereo_sigma_delta_bitstream_dac import sbdac_pkg::*;;
   logic mclk, srst, converter_enable_bit, swap_bit, sample_pair_wr, dma_request;
   sbdac_pair_type sample_pair_data;
   logic irq_status_rd, irq, sample_ready_flag, feed_on, feed_s, clear;
   logic [1:0] irq_enable_wr, irq_disable_wr, irq_clear_wr, irq_status, irq_mask;
   logic c0, c0n, c1, c1n, ce0, ce1;
   logic [15:0] ones0, ones1;
   int err_count, check_count, acc_count, n;

   sbdac_top DUT (.mclk(mclk), .srst(srst), .converter_enable_bit(converter_enable_bit),
      .swap_bit(swap_bit), .sample_pair_wr(sample_pair_wr),
      .sample_pair_data(sample_pair_data), .dma_request(dma_request),
      .irq_status_rd(irq_status_rd), .irq_enable_wr(irq_enable_wr),
      .irq_disable_wr(irq_disable_wr), .irq_clear_wr(irq_clear_wr),
      .irq_status(irq_status), .irq_mask(irq_mask), .irq(irq),
      .sample_ready_flag(sample_ready_flag), .chan0_bitstream_out(c0),
      .chan0_bitstream_out_inv(c0n), .chan1_bitstream_out(c1),
      .chan1_bitstream_out_inv(c1n));
   sbdac_lpf_model lpf0 (.mclk(mclk), .srst(srst), .clear(clear), .bit_true(c0),
      .bit_inv(c0n), .ones_q(ones0), .comp_err_q(ce0));
   sbdac_lpf_model lpf1 (.mclk(mclk), .srst(srst), .clear(clear), .bit_true(c1),
      .bit_inv(c1n), .ones_q(ones1), .comp_err_q(ce1));

   // clock at 256 fs, running before access
   always #25 mclk = ~mclk;
   // writer refills in time
   // a writer that never misses its slot keeps the buffer topped up;
   // feed_on is taken at the edge so the +2 updates of the tasks cannot race it
   always @(posedge mclk) begin
      feed_s = feed_on;
      #2;
      sample_pair_wr = feed_s;
   end
   always @(negedge mclk) begin
      if (sample_pair_wr === 1'b1 && dma_request === 1'b1) acc_count++;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #2;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic check_rng(input logic [31:0] got, input int lo, input int hi);
      check_count++;
      if ($isunknown(got) || got < lo || got > hi) begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h to %h", $time, got, lo, hi);
      end
   endtask
   task automatic mask_op(input logic [1:0] en, input logic [1:0] dis, input logic [1:0] exp);
      irq_enable_wr = en;
      irq_disable_wr = dis;
      tick(1);
      irq_enable_wr = 2'h0;
      irq_disable_wr = 2'h0;
      check(irq_mask, exp);
   endtask
   task automatic pins_idle();
      check({c0, c0n, c1, c1n}, 4'h5);
      check(dma_request, 1'b0);
   endtask

   task automatic test_reset();
      check(irq_status, 2'h0);
      check(irq_mask, 2'h0);
      check(irq, 1'b0);
      pins_idle();
   endtask
   task automatic test_mask();
      mask_op(2'h1, 2'h0, 2'h1);
      mask_op(2'h2, 2'h0, 2'h3);
      mask_op(2'h2, 2'h2, 2'h1);
      mask_op(2'h0, 2'h0, 2'h1);
      check(irq, 1'b0);
   endtask
   task automatic test_fill();
      feed_on = 1'b1;
      tick(10);
      check(acc_count, 0);
      feed_on = 1'b0;
      converter_enable_bit = 1'b1;
      tick(2);
      check(dma_request, 1'b1);
      check(sample_ready_flag, 1'b1);
      check(irq, 1'b0);
      irq_clear_wr = 2'h2;
      tick(1);
      irq_clear_wr = 2'h0;
      check(sample_ready_flag, 1'b0);
      feed_on = 1'b1;
      tick(12);
      check(acc_count, SB_FIFO_DEPTH);
      check(dma_request, 1'b0);
      check(sample_ready_flag, 1'b0);
   endtask
   task automatic window(input int settle);
      tick(settle);
      clear = 1'b1;
      tick(1);
      clear = 1'b0;
      tick(2048);
   endtask
   task automatic test_average();
      window(2048);
      check_rng(ones0, 1127, 2048);
      check_rng(ones1, 0, 921);
      swap_bit = 1'b1;
      window(4096);
      check_rng(ones0, 0, 921);
      check_rng(ones1, 1127, 2048);
      swap_bit = 1'b0;
      check({ce0, ce1}, 2'h0);
      check(irq_status[SB_FLAG_UNDERRUN], 1'b0);
   endtask
   task automatic wait_underrun(input int lim);
      for (n = 0; n < lim && irq_status[SB_FLAG_UNDERRUN] !== 1'b1; n++) tick(1);
      check(irq_status[SB_FLAG_UNDERRUN], 1'b1);
   endtask
   task automatic test_underrun();
      feed_on = 1'b0;
      wait_underrun(3000);
      check(irq, 1'b1);
      irq_status_rd = 1'b1;
      tick(1);
      irq_status_rd = 1'b0;
      check(irq_status, 2'h0);
      check(irq, 1'b0);
      wait_underrun(300);
      irq_clear_wr = 2'h1;
      tick(1);
      irq_clear_wr = 2'h0;
      check(irq_status[SB_FLAG_UNDERRUN], 1'b0);
      converter_enable_bit = 1'b0;
      tick(600);
      check(irq_status[SB_FLAG_UNDERRUN], 1'b0);
      pins_idle();
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // the full sequence needs about 13300 clocks; three times that means a hang
   initial begin
      #2_000_000;
      err_count++;
      stop_test();
   end
   initial begin
      mclk = 1'b0;
      srst = 1'b1;
      converter_enable_bit = 1'b0;
      swap_bit = 1'b0;
      feed_on = 1'b0;
      clear = 1'b0;
      sample_pair_wr = 1'b0;
      irq_status_rd = 1'b0;
      irq_enable_wr = 2'h0;
      irq_disable_wr = 2'h0;
      irq_clear_wr = 2'h0;
      err_count = 0;
      check_count = 0;
      acc_count = 0;
      sample_pair_data = '{right_sample_field: 16'hc000, left_sample_field: 16'h4000};
      tick(4);
      srst = 1'b0;
      tick(1);
      test_reset();
      test_mask();
      test_fill();
      test_average();
      test_underrun();
      stop_test();
   end
endmodule

// file: hdl/sbdac_chan.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: one channel: equalizer, interpolator and modulator
// Assumes: smp_tick once per sample period, os_tick at 128 times that
// Notes:   all state is cleared while run is low
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module sbdac_chan import sbdac_pkg::*; #(
   parameter int CIC_W = SB_CIC_W,
   parameter int SDM_W = SB_SDM_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // pacing
   input wire logic run,
   input wire logic smp_tick,
   input wire logic os_tick,
   // sample in, two's complement
   input wire logic signed [SB_SMP_W-1:0] sample,
   // complementary bitstream
   output logic bit_q,
   output logic bitn_q
);
   localparam logic signed [SDM_W-1:0] FS = SDM_W'(1) <<< SB_SDM_FS_LOG2;
   localparam logic signed [SDM_W:0] LIM = (SDM_W+1)'(1) <<< (SDM_W - 2);
   wire clr = srst || !run;

   function automatic logic signed [SDM_W-1:0] sat(input logic signed [SDM_W:0] v);
      // clamping keeps an overdriven loop from wrapping and latching up
      if (v > LIM) begin
         return SDM_W'(LIM);
      end else if (v < -LIM) begin
         return SDM_W'(-LIM);
      end
      return SDM_W'(v);
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   logic signed [SB_SMP_W-1:0] x1_q, x2_q;
   wire signed [SB_FIR_W-1:0] xe0 = SB_FIR_W'(sample);
   wire signed [SB_FIR_W-1:0] xe1 = SB_FIR_W'(x1_q);
   wire signed [SB_FIR_W-1:0] xe2 = SB_FIR_W'(x2_q);
   // droop equalizer
   // taps -1/4, 3/2, -1/4 lift the top of the band that the combs droop
   wire signed [SB_FIR_W-1:0] fir_sum = (xe1 <<< 2) + (xe1 <<< 1) - xe0 - xe2;
   wire signed [CIC_W-1:0] fir_out = CIC_W'(fir_sum >>> 2);

   always_ff @(posedge mclk) begin
      if (clr) begin
         x1_q <= '0;
         x2_q <= '0;
      end else if (smp_tick) begin
         x1_q <= sample;
         x2_q <= x1_q;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   logic signed [CIC_W-1:0] comb_v [SB_CIC_ORDER+1];
   logic signed [CIC_W-1:0] comb_d_q [SB_CIC_ORDER];
   logic signed [CIC_W-1:0] integ_q [SB_CIC_ORDER];
   logic signed [CIC_W-1:0] comb_out_q;
   logic inj_q;
   assign comb_v[0] = fir_out;

   for (genvar k = 0; k < SB_CIC_ORDER; k++) begin : g_cic
      wire signed [CIC_W-1:0] integ_in;
      assign comb_v[k+1] = comb_v[k] - comb_d_q[k];
      if (k == 0) begin : g_first
         // zero stuffing: one nonzero value per 128 steps
         assign integ_in = inj_q ? comb_out_q : '0;
      end else begin : g_rest
         assign integ_in = integ_q[k-1];
      end
      always_ff @(posedge mclk) begin
         if (clr) begin
            comb_d_q[k] <= '0;
            integ_q[k] <= '0;
         end else begin
            if (smp_tick) begin
               comb_d_q[k] <= comb_v[k];
            end
            if (os_tick) begin
               integ_q[k] <= integ_q[k] + integ_in;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (clr) begin
         comb_out_q <= '0;
         inj_q <= 1'b0;
      end else if (smp_tick) begin
         comb_out_q <= comb_v[SB_CIC_ORDER];
         inj_q <= 1'b1;
      end else if (os_tick) begin
         inj_q <= 1'b0;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   wire signed [SDM_W-1:0] u = SDM_W'(integ_q[SB_CIC_ORDER-1] >>> SB_CIC_SHIFT);
   wire signed [SDM_W-1:0] fb = bit_q ? FS : -FS;
   logic signed [SDM_W-1:0] sd_q [SB_SDM_ORDER];

   for (genvar k = 0; k < SB_SDM_ORDER; k++) begin : g_sdm
      wire signed [SDM_W-1:0] src = (k == 0) ? u : (sd_q[(k == 0) ? 0 : k-1] >>> k);
      wire signed [SDM_W:0] delta = (SDM_W+1)'(src) - (SDM_W+1)'(fb);
      always_ff @(posedge mclk) begin
         if (clr) begin
            sd_q[k] <= '0;
         end else if (os_tick) begin
            sd_q[k] <= sat((SDM_W+1)'(sd_q[k]) + delta);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (clr) begin
         bit_q <= 1'b0;
         bitn_q <= 1'b1;
      end else if (os_tick) begin
         bit_q <= !sd_q[SB_SDM_ORDER-1][SDM_W-1];
         bitn_q <= sd_q[SB_SDM_ORDER-1][SDM_W-1];
      end
   end
endmodule

// file: hdl/sbdac_fifo.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: small sample buffer between the writer and the converter
// Assumes: read data appear in out_data one cycle after a pop
// Notes:   full and empty come from an occupancy count
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module sbdac_fifo import sbdac_pkg::*; #(
   parameter int WIDTH = 32,
   parameter int DEPTH = SB_FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = count_q != (AW+1)'(DEPTH);
   assign out_valid = count_q != '0;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         out_data <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            out_data <= mem_q[rd_ptr_q];
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// file: hdl/sbdac_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: stereo sigma-delta bitstream converter with sample buffer
// Assumes: mclk is the conversion clock, 256 times the sample rate
// Notes:   control and status bits are plain ports, no register bus
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - sample becomes bitstream with proportional average
// - two channels, each true and inverted
// - oversampling ratio fixed at 128
// - three-tap equalizer before the interpolator
// - fourth-order comb interpolator, fs to 128fs
// - third-order modulator with one-bit quantizer
// - runs only after enable written one
// - channel 0 low half, channel 1 high
// - ready flag set when a pair fits
// - late sample sets the underrun flag
// - status read or clear write drops flags
// - dma request follows ready, nothing else needed
// - samples are signed two's complement
// - one interrupt line from masked flags
// - swap bit exchanges halves on write
// - ready flag reads zero when not ready
// - enable sets mask bit, disable clears it
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module sbdac_top import sbdac_pkg::*; #(
   parameter int FIFO_DEPTH = SB_FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control
   input wire logic converter_enable_bit,
   input wire logic swap_bit,
   // sample pair write
   input wire logic sample_pair_wr,
   input wire sbdac_pair_type sample_pair_data,
   output logic dma_request,
   // interrupt control, bit 0 underrun, bit 1 ready
   input wire logic irq_status_rd,
   input wire logic [1:0] irq_enable_wr,
   input wire logic [1:0] irq_disable_wr,
   input wire logic [1:0] irq_clear_wr,
   output logic [1:0] irq_status,
   output logic [1:0] irq_mask,
   output logic irq,
   output logic sample_ready_flag,
   // bitstream pins
   output logic chan0_bitstream_out,
   output logic chan0_bitstream_out_inv,
   output logic chan1_bitstream_out,
   output logic chan1_bitstream_out_inv
);
   ///////////////////////////////////////////////////////////////////////////
   sbdac_state_type state_q, state_d;
   logic [7:0] phase_q;
   logic tick_d_q;
   logic pop_d_q;
   logic ready_d_q;
   logic underrun_q;
   logic sample_ready_flag_q;
   logic [1:0] mask_q;
   sbdac_pair_type cur_pair_q;
   sbdac_pair_type fifo_out;
   sbdac_pair_type push_pair;
   sbdac_pair_type cur_pair;
   logic fifo_in_ready;
   logic fifo_valid;

   wire running = state_q != SB_IDLE;
   wire tick = running && (phase_q == SB_PHASE_LAST);
   wire os_tick = running && phase_q[0];
   wire pop = tick && fifo_valid;
   wire wr_ready = converter_enable_bit && fifo_in_ready;
   wire wr_acc = sample_pair_wr && wr_ready;
   // empty buffer at a sample boundary
   // no underrun before the first sample
   wire ur_event = tick && !fifo_valid && (state_q == SB_RUN);
   wire ready_rise = wr_ready && !ready_d_q;
   wire clr_ur = irq_status_rd || irq_clear_wr[SB_FLAG_UNDERRUN];
   wire clr_tx = irq_status_rd || irq_clear_wr[SB_FLAG_SAMPLE_READY_FLAG];

   assign dma_request = wr_ready;

   // halves placed or swapped at write
   assign push_pair.left_sample_field = swap_bit ? sample_pair_data.right_sample_field
                                                 : sample_pair_data.left_sample_field;
   assign push_pair.right_sample_field = swap_bit ? sample_pair_data.left_sample_field
                                                  : sample_pair_data.right_sample_field;
   // an underrun repeats the last pair rather than jumping to zero
   assign cur_pair = pop_d_q ? fifo_out : cur_pair_q;

   ///////////////////////////////////////////////////////////////////////////
   // single clock, no crossing needed
   sbdac_fifo #(
      .WIDTH($bits(sbdac_pair_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_valid(wr_acc),
      .in_ready(fifo_in_ready),
      .in_data(push_pair),
      .out_valid(fifo_valid),
      .out_ready(tick),
      .out_data(fifo_out)
   );

   ///////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      case (state_q)
         SB_IDLE: begin
            if (converter_enable_bit) begin
               state_d = SB_PRIME;
            end
         end
         SB_PRIME: begin
            if (!converter_enable_bit) begin
               state_d = SB_IDLE;
            end else if (pop) begin
               state_d = SB_RUN;
            end
         end
         SB_RUN: begin
            if (!converter_enable_bit) begin
               state_d = SB_IDLE;
            end
         end
         default: begin
            state_d = SB_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= SB_IDLE;
         phase_q <= '0;
         tick_d_q <= 1'b0;
         pop_d_q <= 1'b0;
         cur_pair_q <= '0;
      end else begin
         state_q <= state_d;
         phase_q <= running ? phase_q + 1'b1 : '0;
         tick_d_q <= tick && (state_d != SB_IDLE);
         pop_d_q <= pop;
         cur_pair_q <= cur_pair;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // ready flag set as readiness rises, held until cleared, dropped when not ready
   always_ff @(posedge mclk) begin
      if (srst) begin
         underrun_q <= 1'b0;
         sample_ready_flag_q <= 1'b0;
         ready_d_q <= 1'b0;
         mask_q <= SB_FLAGS_RESET;
      end else begin
         ready_d_q <= wr_ready;
         underrun_q <= ur_event || (underrun_q && !clr_ur);
         sample_ready_flag_q <= wr_ready && (ready_rise || (sample_ready_flag_q && !clr_tx));
         mask_q <= (mask_q | irq_enable_wr) & ~irq_disable_wr;
      end
   end

   assign irq_status = {sample_ready_flag_q, underrun_q};
   assign irq_mask = mask_q;
   assign sample_ready_flag = sample_ready_flag_q;
   assign irq = |(irq_status & irq_mask);

   ///////////////////////////////////////////////////////////////////////////
   // two channels, signed samples
   sbdac_chan u_chan0 (
      .mclk(mclk),
      .srst(srst),
      .run(running),
      .smp_tick(tick_d_q),
      .os_tick(os_tick),
      .sample(cur_pair.left_sample_field),
      .bit_q(chan0_bitstream_out),
      .bitn_q(chan0_bitstream_out_inv)
   );

   sbdac_chan u_chan1 (
      .mclk(mclk),
      .srst(srst),
      .run(running),
      .smp_tick(tick_d_q),
      .os_tick(os_tick),
      .sample(cur_pair.right_sample_field),
      .bit_q(chan1_bitstream_out),
      .bitn_q(chan1_bitstream_out_inv)
   );

   ///////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // an 8-bit phase that steps by one while running wraps every 256 clocks
   a_tick_period: assert property (
      (running && $past(running)) |-> phase_q == $past(phase_q) + 8'h01)
      else $error("sample phase counter skipped a step");
   a_ready_rise: assert property (
      (wr_ready && !ready_d_q) |=> sample_ready_flag)
      else $error("ready flag missed readiness");
   a_ready_low: assert property (
      !wr_ready |=> !sample_ready_flag)
      else $error("ready flag high while not ready");
   a_underrun_set: assert property (
      ur_event |=> irq_status[SB_FLAG_UNDERRUN] && irq_status[SB_FLAG_UNDERRUN])
      else $error("underrun not recorded");
   a_status_clear: assert property (
      (irq_status_rd && !ur_event) |=> !irq_status[SB_FLAG_UNDERRUN])
      else $error("status read did not clear underrun");
   a_mask_set: assert property (
      (irq_enable_wr[0] && !irq_disable_wr[0]) |=> irq_mask[0] ##1 (irq_mask[0] || $past(irq_disable_wr[0])))
      else $error("mask enable lost");
   a_mask_clear: assert property (
      irq_disable_wr[1] |=> !irq_mask[1])
      else $error("mask disable ignored");
   a_irq_line: assert property (
      (irq_status[SB_FLAG_UNDERRUN] && irq_mask[SB_FLAG_UNDERRUN]) |-> irq)
      else $error("interrupt line not raised");
   a_idle_quiet: assert property (
      (!converter_enable_bit && state_q == SB_IDLE) |=> !chan0_bitstream_out && !ur_event)
      else $error("disabled converter active");
   a_start_enable: assert property (
      (state_q == SB_IDLE && !converter_enable_bit) |=> state_q == SB_IDLE && phase_q == '0)
      else $error("started without enable");
   a_pins_compl: assert property (
      chan0_bitstream_out != chan0_bitstream_out_inv
      && chan1_bitstream_out != chan1_bitstream_out_inv)
      else $error("bitstream pins not complementary");
   a_swap_write: assert property (
      (wr_acc && swap_bit) |-> push_pair.left_sample_field == sample_pair_data[31:16])
      else $error("swap not applied");
   a_dma_ready: assert property (
      dma_request |-> converter_enable_bit && fifo_in_ready)
      else $error("dma request without readiness");

   c_underrun: cover property (ur_event);
   c_fifo_full: cover property (converter_enable_bit && !fifo_in_ready);
   c_swap_write: cover property (wr_acc && swap_bit);
   c_irq_raise: cover property (!irq ##1 irq);
endmodule
